/* scrb_bank.sv */
// Configuration register bank of a fractional-N synthesizer with serial load
// Overview of operation
// RULE_01: Control code 000 routes the word to the integer/fraction register.
// RULE_02: Integer/fraction bit 31 enables the frequency ramp.
// RULE_03: Integer/fraction bits 30:27 pick the monitor multiplexer source.
// RULE_04: Integer/fraction bits 26:15 give the 12-bit integer divide value.
// RULE_05: Fraction is 25 bits: high 12 from word zero, low 13 from word one.
// RULE_06: Control code 001 routes the word to the low fraction/phase register.
// RULE_07: Low fraction bit 28 enables phase adjust using phase word bits 14:3.
// RULE_08: Phase advances by phase word times 360 degrees over 4096.
// RULE_09: A new phase word acts only after a later write to word zero.
// RULE_10: Host writes reserved bits zero; phase word zero when unused.
// RULE_11: Control code 010 routes the word to the reference divider register.
// RULE_12: Host enables slip reduction only with positive polarity, minimum current.
// RULE_13: Reference divider bits 27:24 set charge pump current.
// RULE_14: Reference divider bit 22 selects 4/5 or 8/9 prescaler.
// RULE_15: Host uses 8/9 above 8 GHz; integer at least 23 or 75.
// RULE_16: Bit 21 inserts a divide-by-two stage after the reference counter.
// RULE_17: Bit 20 clear uses falling edge only; set doubles, both edges active.
// RULE_18: Bits 19:15 set the reference counter, ratios 1 to 32.
// RULE_19: Bits 14:3 load the 12-bit first ramp clock divider.
// RULE_20: Host writes code 011 for function register, reserved zero, bit 17 one.
// RULE_21: Function bits 24:22 pick bleed level; bit 21 enables bleed.
// RULE_22: Function bit 16 controls lock loss indication, also on lost reference.
// RULE_23: Destination latch is decoded from the three low bits, codes 000 to 111.
// RULE_24: Double-buffered settings take effect only after a later write to word zero.
// RULE_25: Words shift in MSB first; load strobe edge moves them into the latch.
// RULE_26: Delay register, code 111, holds 12-bit start word and flags in 23:15.
`default_nettype none
`include "scrb_regs.svh"
module scrb_bank
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load,
	input wire logic ref_in,
	output logic ramp_enable,
	output logic [3:0] monitor_mux_select,
	output logic [11:0] integer_value,
	output logic [24:0] fractional_divide_value,
	output logic phase_adjust_enable,
	output logic [11:0] phase_accum,
	output logic cycle_slip_reducer_enable,
	output logic [3:0] charge_pump_current,
	output logic prescaler_high,
	output logic reference_halver_enable,
	output logic reference_doubler_enable,
	output logic [4:0] reference_count,
	output logic [11:0] ramp_clock_divider,
	output logic [2:0] bleed_current_level,
	output logic bleed_enable,
	output logic lock_loss_indication,
	output logic [11:0] delay_start_word,
	output logic [8:0] delay_flags,
	output logic pfd_ref_tick
);
	// ----------------------------------------
	// Serial front end
	// ----------------------------------------
	scrb_shift_if sh ();

	scrb_shifter u_shifter
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.ser_load(ser_load),
		.sh(sh)
	);

	// ----------------------------------------
	// Latches and double buffers
	// ----------------------------------------
	scrb_pkg::scrb_sel_type sel;
	scrb_pkg::scrb_word_type word0;
	scrb_pkg::scrb_word_type next_word0;
	scrb_pkg::scrb_word_type word1;
	scrb_pkg::scrb_word_type next_word1;
	scrb_pkg::scrb_word_type word2;
	scrb_pkg::scrb_word_type next_word2;
	scrb_pkg::scrb_word_type word3;
	scrb_pkg::scrb_word_type next_word3;
	scrb_pkg::scrb_word_type word7;
	scrb_pkg::scrb_word_type next_word7;
	scrb_pkg::scrb_word_type act1;
	scrb_pkg::scrb_word_type next_act1;
	scrb_pkg::scrb_word_type act2;
	scrb_pkg::scrb_word_type next_act2;
	logic [11:0] next_phase_accum;
	logic w0;

	assign sel = sh.word[`SCRB_CTRL_MSB:`SCRB_CTRL_LSB]; // [RULE_23]
	assign w0 = sh.load && sel == `SCRB_SEL_INTFRAC; // [RULE_01]

	// Decode destination; staged words copy to active set on word zero write
	always_comb
	begin
		next_word0 = word0;
		next_word1 = word1;
		next_word2 = word2;
		next_word3 = word3;
		next_word7 = word7;
		next_act1 = act1;
		next_act2 = act2;
		next_phase_accum = phase_accum;
		if (sh.load)
		begin
			unique case (sel) // [RULE_23]
				`SCRB_SEL_INTFRAC: next_word0 = sh.word; // [RULE_01]
				`SCRB_SEL_LOWFRAC: next_word1 = sh.word; // [RULE_06]
				`SCRB_SEL_REFDIV: next_word2 = sh.word; // [RULE_11]
				`SCRB_SEL_FUNC: next_word3 = sh.word;
				`SCRB_SEL_DELAY: next_word7 = sh.word; // [RULE_26]
				default: next_word0 = word0; // Codes owned by other banks
			endcase
		end
		if (w0)
		begin
			next_act1 = word1; // [RULE_24]
			next_act2 = word2; // [RULE_24]
			// Phase step applied once per word zero write, modulo a full turn
			if (word1[`SCRB_R1_PHEN_BIT])
				next_phase_accum = phase_accum + word1[`SCRB_R1_PH_MSB:`SCRB_R1_PH_LSB]; // [RULE_07] [RULE_08] [RULE_09]
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			word0 <= `SCRB_WORD_RESET;
			word1 <= `SCRB_WORD_RESET;
			word2 <= `SCRB_WORD_RESET;
			word3 <= `SCRB_WORD_RESET;
			word7 <= `SCRB_WORD_RESET;
			act1 <= `SCRB_WORD_RESET;
			act2 <= `SCRB_WORD_RESET;
			phase_accum <= `SCRB_ACC_RESET;
		end
		else
		begin
			word0 <= next_word0;
			word1 <= next_word1;
			word2 <= next_word2;
			word3 <= next_word3;
			word7 <= next_word7;
			act1 <= next_act1;
			act2 <= next_act2;
			phase_accum <= next_phase_accum;
		end
	end

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	// Word zero fields act at once
	assign ramp_enable = word0[`SCRB_R0_RAMP_BIT]; // [RULE_02]
	assign monitor_mux_select = word0[`SCRB_R0_MUX_MSB:`SCRB_R0_MUX_LSB]; // [RULE_03]
	assign integer_value = word0[`SCRB_R0_INT_MSB:`SCRB_R0_INT_LSB]; // [RULE_04]
	assign fractional_divide_value = {word0[`SCRB_R0_FRACTIONAL_DIVIDE_VALUE_MSB:`SCRB_R0_FRACTIONAL_DIVIDE_VALUE_LSB],
		act1[`SCRB_R1_FRACTIONAL_DIVIDE_VALUE_MSB:`SCRB_R1_FRACTIONAL_DIVIDE_VALUE_LSB]}; // [RULE_05]
	assign phase_adjust_enable = act1[`SCRB_R1_PHEN_BIT]; // [RULE_07]

	// Non-buffered reference divider bits follow the latch directly
	assign cycle_slip_reducer_enable = word2[`SCRB_R2_CSR_BIT];
	assign prescaler_high = word2[`SCRB_R2_PRESC_BIT]; // [RULE_14]
	assign charge_pump_current = act2[`SCRB_R2_CP_MSB:`SCRB_R2_CP_LSB]; // [RULE_13]
	assign reference_halver_enable = act2[`SCRB_R2_HALF_BIT]; // [RULE_16]
	assign reference_doubler_enable = act2[`SCRB_R2_DBL_BIT]; // [RULE_17]
	assign reference_count = act2[`SCRB_R2_RCNT_MSB:`SCRB_R2_RCNT_LSB]; // [RULE_18]
	assign ramp_clock_divider = act2[`SCRB_R2_CLK1_MSB:`SCRB_R2_CLK1_LSB]; // [RULE_19]

	assign bleed_current_level = word3[`SCRB_R3_BLEED_MSB:`SCRB_R3_BLEED_LSB]; // [RULE_21]
	assign bleed_enable = word3[`SCRB_R3_BLEEDEN_BIT]; // [RULE_21]
	assign lock_loss_indication = word3[`SCRB_R3_LOL_BIT]; // [RULE_22]

	assign delay_start_word = word7[`SCRB_R7_DS_MSB:`SCRB_R7_DS_LSB]; // [RULE_26]
	assign delay_flags = word7[`SCRB_R7_FLAG_MSB:`SCRB_R7_FLAG_LSB]; // [RULE_26]

	// ----------------------------------------
	// Reference path
	// ----------------------------------------
	logic ref_d;
	logic next_ref_d;
	logic [4:0] rcnt;
	logic [4:0] next_rcnt;
	logic half_q;
	logic next_half_q;
	logic tick;
	logic next_tick;
	logic ref_edge;
	logic rc_out;

	// Falling edge only, or both edges when doubled; counter value 0 means 32
	always_comb
	begin
		next_ref_d = ref_in;
		ref_edge = reference_doubler_enable ? (ref_in != ref_d) : (ref_d && !ref_in); // [RULE_17]
		next_rcnt = rcnt;
		rc_out = 1'b0;
		next_half_q = half_q;
		next_tick = 1'b0;
		if (ref_edge)
		begin
			if (rcnt + 5'h01 == reference_count)
			begin
				next_rcnt = 5'h00;
				rc_out = 1'b1; // [RULE_18]
			end
			else
				next_rcnt = rcnt + 5'h01;
		end
		if (rc_out)
		begin
			next_half_q = !half_q;
			next_tick = reference_halver_enable ? half_q : 1'b1; // [RULE_16]
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ref_d <= 1'b0;
			rcnt <= 5'h00;
			half_q <= 1'b0;
			tick <= 1'b0;
		end
		else
		begin
			ref_d <= next_ref_d;
			rcnt <= next_rcnt;
			half_q <= next_half_q;
			tick <= next_tick;
		end
	end

	assign pfd_ref_tick = tick;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_phase_step;
		@(posedge core_clk) disable iff (!rst_b)
		(w0 && word1[`SCRB_R1_PHEN_BIT]) |=> phase_accum == 12'($past(phase_accum) + $past(word1[14:3]));
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("phase step not applied"); // [RULE_08]

	property p_phase_hold;
		@(posedge core_clk) disable iff (!rst_b)
		!w0 |=> $stable(phase_accum);
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase moved without word zero write"); // [RULE_09]

	property p_buffer_hold;
		@(posedge core_clk) disable iff (!rst_b)
		!w0 |=> ($stable(charge_pump_current) && $stable(reference_count) && $stable(ramp_clock_divider));
	endproperty
	a_buffer_hold: assert property (p_buffer_hold) else $error("buffered field changed early"); // [RULE_24]

	property p_buffer_take;
		@(posedge core_clk) disable iff (!rst_b)
		w0 |=> fractional_divide_value[12:0] == $past(word1[27:15]);
	endproperty
	a_buffer_take: assert property (p_buffer_take) else $error("low fraction not transferred"); // [RULE_05]

	property p_route_r0;
		@(posedge core_clk) disable iff (!rst_b)
		w0 |=> (integer_value == $past(sh.word[26:15]) && ramp_enable == $past(sh.word[31]));
	endproperty
	a_route_r0: assert property (p_route_r0) else $error("word zero not latched"); // [RULE_01]

	property p_route_r2;
		@(posedge core_clk) disable iff (!rst_b)
		(sh.load && sel == 3'h2) |=> prescaler_high == $past(sh.word[22]);
	endproperty
	a_route_r2: assert property (p_route_r2) else $error("reference divider not latched"); // [RULE_11]

	property p_route_r3;
		@(posedge core_clk) disable iff (!rst_b)
		(sh.load && sel == 3'h3) |=> lock_loss_indication == $past(sh.word[16]);
	endproperty
	a_route_r3: assert property (p_route_r3) else $error("function word not latched"); // [RULE_22]

	property p_route_r7;
		@(posedge core_clk) disable iff (!rst_b)
		(sh.load && sel == 3'h7) |=> delay_start_word == $past(sh.word[14:3]);
	endproperty
	a_route_r7: assert property (p_route_r7) else $error("delay word not latched"); // [RULE_26]

	property p_route_r1;
		@(posedge core_clk) disable iff (!rst_b)
		(sh.load && sel == 3'h1) |=> word1 == $past(sh.word);
	endproperty
	a_route_r1: assert property (p_route_r1) else $error("low fraction word not latched"); // [RULE_06]

	property p_tick_single;
		@(posedge core_clk) disable iff (!rst_b)
		pfd_ref_tick |-> $past(ref_edge);
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("reference tick without a counted edge"); // [RULE_18]

	c_word0: cover property (@(posedge core_clk) disable iff (!rst_b) w0);
	c_phase: cover property (@(posedge core_clk) disable iff (!rst_b) w0 && word1[28]);
	c_delay: cover property (@(posedge core_clk) disable iff (!rst_b) sh.load && sel == 3'h7);
	c_tick: cover property (@(posedge core_clk) disable iff (!rst_b) pfd_ref_tick);
endmodule
`default_nettype wire

/* scrb_regs.svh */
// Register field positions, codes and reset values of the synthesizer configuration bank
`ifndef SCRB_REGS_SVH
`define SCRB_REGS_SVH

// Control code field
`define SCRB_CTRL_MSB 2
`define SCRB_CTRL_LSB 0
`define SCRB_SEL_INTFRAC 3'h0
`define SCRB_SEL_LOWFRAC 3'h1
`define SCRB_SEL_REFDIV 3'h2
`define SCRB_SEL_FUNC 3'h3
`define SCRB_SEL_DELAY 3'h7

// Integer/fraction word fields
`define SCRB_R0_RAMP_BIT 31
`define SCRB_R0_MUX_MSB 30
`define SCRB_R0_MUX_LSB 27
`define SCRB_R0_INT_MSB 26
`define SCRB_R0_INT_LSB 15
`define SCRB_R0_FRACTIONAL_DIVIDE_VALUE_MSB 14
`define SCRB_R0_FRACTIONAL_DIVIDE_VALUE_LSB 3

// Low fraction / phase word fields
`define SCRB_R1_PHEN_BIT 28
`define SCRB_R1_FRACTIONAL_DIVIDE_VALUE_MSB 27
`define SCRB_R1_FRACTIONAL_DIVIDE_VALUE_LSB 15
`define SCRB_R1_PH_MSB 14
`define SCRB_R1_PH_LSB 3

// Reference divider word fields
`define SCRB_R2_CSR_BIT 28
`define SCRB_R2_CP_MSB 27
`define SCRB_R2_CP_LSB 24
`define SCRB_R2_PRESC_BIT 22
`define SCRB_R2_HALF_BIT 21
`define SCRB_R2_DBL_BIT 20
`define SCRB_R2_RCNT_MSB 19
`define SCRB_R2_RCNT_LSB 15
`define SCRB_R2_CLK1_MSB 14
`define SCRB_R2_CLK1_LSB 3

// Function word fields
`define SCRB_R3_BLEED_MSB 24
`define SCRB_R3_BLEED_LSB 22
`define SCRB_R3_BLEEDEN_BIT 21
`define SCRB_R3_LOL_BIT 16

// Ramp delay word fields
`define SCRB_R7_FLAG_MSB 23
`define SCRB_R7_FLAG_LSB 15
`define SCRB_R7_DS_MSB 14
`define SCRB_R7_DS_LSB 3

// Reset values
`define SCRB_WORD_RESET 32'h0000_0000
`define SCRB_PHASE_RESET 12'h000
`define SCRB_ACC_RESET 12'h000

`endif

/* scrb_pkg.sv */
// Shared types of the synthesizer configuration bank
`default_nettype none
package scrb_pkg;
	typedef logic [31:0] scrb_word_type;
	typedef logic [2:0] scrb_sel_type;
	typedef enum logic [1:0]
	{
		SCRB_SHIFT_IDLE = 2'b01,
		SCRB_SHIFT_BUSY = 2'b10
	} scrb_shift_state_type;
endpackage
`default_nettype wire

/* scrb_shift_if.sv */
// Interface between serial shifter and register bank
`default_nettype none
interface scrb_shift_if;
	logic load;
	scrb_pkg::scrb_word_type word;
	modport shifter (output load, output word);
	modport bank (input load, input word);
endinterface
`default_nettype wire

/* scrb_shifter.sv */
// Serial input shift register with load strobe edge detection
`default_nettype none
`include "scrb_regs.svh"
module scrb_shifter
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load,
	scrb_shift_if.shifter sh
);
	// ----------------------------------------
	// Shift and latch
	// ----------------------------------------
	scrb_pkg::scrb_word_type shreg;
	scrb_pkg::scrb_word_type next_shreg;
	scrb_pkg::scrb_word_type word_q;
	scrb_pkg::scrb_word_type next_word_q;
	logic clk_d;
	logic next_clk_d;
	logic load_d;
	logic next_load_d;
	logic load_p;
	logic next_load_p;
	scrb_pkg::scrb_shift_state_type st;
	scrb_pkg::scrb_shift_state_type next_st;

	// Shift MSB first on serial clock rise; hold while load is high
	always_comb
	begin
		next_clk_d = ser_clk;
		next_load_d = ser_load;
		next_shreg = shreg;
		next_word_q = word_q;
		next_load_p = 1'b0;
		next_st = st;
		unique case (st)
			scrb_pkg::SCRB_SHIFT_IDLE:
			begin
				if (!ser_load)
					next_st = scrb_pkg::SCRB_SHIFT_BUSY;
			end
			scrb_pkg::SCRB_SHIFT_BUSY:
			begin
				if (ser_clk && !clk_d && !ser_load)
					next_shreg = {shreg[30:0], ser_data}; // [RULE_25]
				if (ser_load && !load_d)
				begin
					next_word_q = shreg; // [RULE_25]
					next_load_p = 1'b1;
					next_st = scrb_pkg::SCRB_SHIFT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shreg <= `SCRB_WORD_RESET;
			word_q <= `SCRB_WORD_RESET;
			clk_d <= 1'b0;
			load_d <= 1'b1;
			load_p <= 1'b0;
			st <= scrb_pkg::SCRB_SHIFT_IDLE;
		end
		else
		begin
			shreg <= next_shreg;
			word_q <= next_word_q;
			clk_d <= next_clk_d;
			load_d <= next_load_d;
			load_p <= next_load_p;
			st <= next_st;
		end
	end

	assign sh.load = load_p;
	assign sh.word = word_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_load_latches;
		@(posedge core_clk) disable iff (!rst_b)
		(st == scrb_pkg::SCRB_SHIFT_BUSY && ser_load && !load_d) |=> (sh.load && sh.word == $past(shreg));
	endproperty
	a_load_latches: assert property (p_load_latches) else $error("load strobe did not latch word"); // [RULE_25]

	property p_load_pulse;
		@(posedge core_clk) disable iff (!rst_b)
		sh.load |=> !sh.load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load pulse longer than one cycle"); // [RULE_25]
endmodule
`default_nettype wire

/* scrb_host_model.sv */
// Host controller model that shifts words into the serial load port
`default_nettype none
module scrb_host_model
(
	input wire logic core_clk,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_load
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Idle levels
	// ----------------------------------------
	// Serial clock parked low between frames
	initial
	begin
		ser_clk = 1'h0;
		ser_data = 1'h0;
		ser_load = 1'h0;
	end

	// ----------------------------------------
	// Word transfer
	// ----------------------------------------
	// Data leads clock by a cycle; each clock level lasts two cycles
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--)
		begin
			@(posedge core_clk);
			ser_data <= w[i];
			@(posedge core_clk);
			ser_clk <= 1'h1;
			repeat (2) @(posedge core_clk);
			ser_clk <= 1'h0;
		end
		// Data released: inverse of last bit, so a stale level never helps
		@(posedge core_clk);
		ser_data <= ~w[0];
		ser_load <= 1'h1;
		repeat (3) @(posedge core_clk);
		ser_load <= 1'h0;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the synthesizer configuration bank
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Words sent by the host
	// ----------------------------------------
	// Reserved bits zero, integer 75 suits the 8/9 prescaler
	localparam logic [31:0] w2_first = {3'h0, 1'h0, 4'ha, 1'h0, 1'h1, 1'h1, 1'h1, 5'h03, 12'h5a5, 3'h2};
	// Slip reducer only with minimum current and halved reference for even duty
	localparam logic [31:0] w2_second = {3'h0, 1'h1, 4'h0, 1'h0, 1'h0, 1'h1, 1'h0, 5'h00, 12'h5a5, 3'h2};
	localparam logic [31:0] w1 = {3'h0, 1'h1, 13'h1abc, 12'h200, 3'h1};
	localparam logic [31:0] w0 = {1'h1, 4'h9, 12'h04b, 12'h123, 3'h0};
	// Bit 17 set, positive detector polarity
	localparam logic [31:0] w3 = {7'h00, 3'h5, 1'h1, 3'h0, 1'h1, 1'h1, 13'h0008, 3'h3};
	localparam logic [31:0] w7 = {8'h00, 9'h1a5, 12'hc3f, 3'h7};

	logic core_clk, rst_b, ref_in, ser_clk, ser_data, ser_load;
	logic ramp_enable, phase_adjust_enable, cycle_slip_reducer_enable, prescaler_high;
	logic reference_halver_enable, reference_doubler_enable, bleed_enable, lock_loss_indication, pfd_ref_tick;
	logic [3:0] monitor_mux_select, charge_pump_current;
	logic [11:0] integer_value, phase_accum, ramp_clock_divider, delay_start_word;
	logic [24:0] fractional_divide_value;
	logic [4:0] reference_count;
	logic [2:0] bleed_current_level;
	logic [8:0] delay_flags;
	logic [106:0] all_out;
	int err_count = 0;
	int tests_run = 0;

	assign all_out = {ramp_enable, monitor_mux_select, integer_value, fractional_divide_value,
		phase_adjust_enable, phase_accum, cycle_slip_reducer_enable, charge_pump_current, prescaler_high,
		reference_halver_enable, reference_doubler_enable, reference_count, ramp_clock_divider,
		bleed_current_level, bleed_enable, lock_loss_indication, delay_start_word, delay_flags, pfd_ref_tick};

	// ----------------------------------------
	// Clock, design and host
	// ----------------------------------------
	// Free-running core clock
	initial
	begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end

	scrb_bank dut (.core_clk, .rst_b, .ser_clk, .ser_data, .ser_load, .ref_in, .ramp_enable,
		.monitor_mux_select, .integer_value, .fractional_divide_value, .phase_adjust_enable, .phase_accum,
		.cycle_slip_reducer_enable, .charge_pump_current, .prescaler_high, .reference_halver_enable,
		.reference_doubler_enable, .reference_count, .ramp_clock_divider, .bleed_current_level, .bleed_enable,
		.lock_loss_indication, .delay_start_word, .delay_flags, .pfd_ref_tick);

	scrb_host_model host (.core_clk, .ser_clk, .ser_data, .ser_load);

	// ----------------------------------------
	// Compare and closing tasks
	// ----------------------------------------
	task check_val(input logic [127:0] got, input logic [127:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Tick counts checked against an expected window
	task check_cnt(input int n, input int lo, input int hi);
		tests_run++;
		if (n < lo || n > hi)
		begin
			err_count++;
			$display("Error %0t: tick count %0d outside %0d to %0d", $time, n, lo, hi);
		end
	endtask

	task stop_test;
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Buffered fields wait for word zero; direct ones act at once
	task cfg_buffered;
		host.send(w2_first);
		check_val(prescaler_high, 1'h1, "prescaler direct");
		check_val({charge_pump_current, reference_count, ramp_clock_divider}, 21'h0, "ref staged");
		host.send(w1);
		check_val({phase_adjust_enable, fractional_divide_value, phase_accum}, 38'h0, "low staged");
		host.send(w0);
		check_val({ramp_enable, monitor_mux_select, integer_value}, 17'h1904b, "word zero");
		check_val(monitor_mux_select, 4'h9, "monitor select");
		check_val(integer_value, 12'h04b, "integer");
		check_val(fractional_divide_value, {12'h123, 13'h1abc}, "fraction");
		check_val({phase_adjust_enable, phase_accum}, 13'h1200, "phase");
		check_val(charge_pump_current, 4'ha, "pump current");
		check_val({reference_halver_enable, reference_doubler_enable}, 2'h3, "ref halver doubler");
		check_val(reference_count, 5'h03, "ref count");
		check_val(ramp_clock_divider, 12'h5a5, "ramp divider");
		check_val(cycle_slip_reducer_enable, 1'h0, "slip reducer off");
	endtask

	task cfg_function_delay;
		host.send(w3);
		check_val({bleed_current_level, bleed_enable, lock_loss_indication}, 5'h17, "function");
		host.send(w7);
		check_val({delay_flags, delay_start_word}, {9'h1a5, 12'hc3f}, "delay");
	endtask

	// Codes 4 to 6 must leave every latch alone
	task refused_codes;
		for (int c = 4; c <= 6; c++)
			host.send({29'h1fff_ffff, 3'(c)});
		check_val({integer_value, bleed_current_level, delay_start_word}, {12'h04b, 3'h5, 12'hc3f}, "refused");
		check_val({ramp_clock_divider, phase_accum, delay_flags}, {12'h5a5, 12'h200, 9'h1a5}, "refused");
	endtask

	// Toggle the reference and count detector ticks; two extra core clock cycles without toggles catch the last tick
	task automatic ref_ticks(input int toggles, input int lo, input int hi);
		int n;
		n = 0;
		for (int i = 0; i < 2 * toggles + 2; i++)
		begin
			@(posedge core_clk);
			if (pfd_ref_tick === 1'h1)
				n++;
			if (i % 2 == 1 && i < 2 * toggles)
				ref_in <= ~ref_in;
		end
		check_cnt(n, lo, hi);
	endtask

	// Second setup: phase accumulates, divider back to 32, falling edge only
	task cfg_second;
		host.send(w2_second);
		check_val({cycle_slip_reducer_enable, prescaler_high}, 2'h2, "direct bits");
		check_val(reference_doubler_enable, 1'h1, "doubler held");
		host.send(w0);
		check_val(phase_accum, 12'h400, "phase step");
		check_val({charge_pump_current, reference_halver_enable, reference_doubler_enable, reference_count},
			12'h040, "ref second");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		rst_b = 1'h0;
		ref_in = 1'h0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge core_clk);
		check_val(all_out, 128'h0, "reset state");
		cfg_buffered;
		cfg_function_delay;
		refused_codes;
		ref_ticks(120, 20, 20);
		cfg_second;
		ref_ticks(256, 2, 2);
		stop_test;
	end

	// Whole run is near 2100 cycles, so this only trips on a hang
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		$display("Error %0t: watchdog expired", $time);
		stop_test;
	end
endmodule
`default_nettype wire
